// ---- design/pinmux_pkg.sv ----
package pinmux_pkg;

  // Byte addresses of the register words
  localparam logic [7:0] OFS_PORT1_DIR   = 8'h00;
  localparam logic [7:0] OFS_PORT2_DIR   = 8'h04;
  localparam logic [7:0] OFS_PORT5_DIR   = 8'h08;
  localparam logic [7:0] OFS_BUS_REL     = 8'h0c;
  localparam logic [7:0] OFS_UPPER_ADR   = 8'h10;
  localparam logic [7:0] OFS_MODE_STAT   = 8'h14;
  localparam logic [7:0] OFS_PIN_STAT    = 8'h18;
  localparam logic [7:0] OFS_MAP_STAT    = 8'h1c;

  localparam logic [7:0] DIR_RST         = 8'h00;
  localparam logic [3:0] P5_DIR_RST      = 4'h0;
  // Upper address enable bits 7..5, active when written zero; all ones at reset
  localparam logic [7:0] UPPER_RST       = 8'hff;
  localparam int         UPPER_LSB       = 5;
  localparam logic [2:0] UPPER_ENABLE    = 3'h0;
  // Mode status: bits 7..6 read 1, 5..3 read 0
  localparam logic [7:0] MODE_STAT_FIX   = 8'hc0;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  localparam int         AREA_COUNT      = 8;
  localparam int         BUS_WIDTH_BITS  = 8;

  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [2:0] MODE_6 = 3'h6;
  localparam logic [2:0] MODE_7 = 3'h7;

  // Base of the internal RAM/IO window (bits 23..20 of the address)
  localparam logic [3:0] MAP_BASE_1M  = 4'h0;
  localparam logic [3:0] MAP_BASE_16M = 4'hf;

  // Area number = address bits 23..21 in 16 Mbyte modes, 19..17 in 1 Mbyte modes
  localparam int AREA_LSB_16M = 21;
  localparam int AREA_LSB_1M  = 17;

endpackage : pinmux_pkg

// ---- design/mode_sampler.sv ----
`timescale 1ns/1ns
// Synchronises the mode pins; the status latch is updated only by a read
module mode_sampler
  import pinmux_pkg::*;
(
  input  wire logic       mclk_i,          // System clock
  input  wire logic       rstn_i,          // Async reset, low
  input  wire logic [2:0] mode_pins_i,     // Raw mode pins
  input  wire logic       read_i,          // Status read strobe
  output logic      [2:0] mode_o,          // Synchronised mode
  output logic      [2:0] latched_o        // Level latched at read
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] lat;
  } samp_s;

  samp_s st_r;
  samp_s st_nxt;

  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.s1  = mode_pins_i;
    st_nxt.s2  = st_r.s1;
    if (read_i)
    begin
      st_nxt.lat = st_r.s2; // RULE20
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign mode_o    = st_r.s2;
  assign latched_o = st_r.lat;
endmodule : mode_sampler

// ---- design/area_decode.sv ----
`timescale 1ns/1ns
// Registered area number and internal-window hit for a CPU address
module area_decode
  import pinmux_pkg::*;
(
  input  wire logic        mclk_i,         // System clock
  input  wire logic        rstn_i,         // Async reset, low
  input  wire logic        wide_i,         // 16 Mbyte mode
  input  wire logic [23:0] addr_i,         // CPU address
  output logic      [2:0]  area_o,         // Area 0..7
  output logic             internal_o      // Hits RAM/IO window
);
  typedef struct packed {
    logic [2:0] area;
    logic       hit;
  } dec_s;

  dec_s st_r;
  dec_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (wide_i)
    begin
      st_nxt.area = addr_i[AREA_LSB_16M +: 3]; // RULE16
      st_nxt.hit  = (addr_i[23:20] == MAP_BASE_16M); // RULE15
    end
    else
    begin
      st_nxt.area = addr_i[AREA_LSB_1M +: 3]; // RULE16
      st_nxt.hit  = (addr_i[23:20] == MAP_BASE_1M) && (addr_i[19:16] == 4'hf); // RULE15
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign area_o     = st_r.area;
  assign internal_o = st_r.hit;
endmodule : area_decode

// ---- design/mode_address_pin_config.sv ----
`timescale 1ns/1ns
// Contract
// (RULE1) Mode 1: ports 1, 2, 5 drive A19..A0, 1 Mbyte space.
// (RULE2) After reset every expanded mode uses 8-bit accesses everywhere.
// (RULE3) Mode 3: ports 1, 2, 5 and part of port A drive A23..A0.
// (RULE4) Mode 3: A23..A21 valid only after bus release bits 7..5 are zero.
// (RULE5) 16 Mbyte modes: A20 is always an address output.
// (RULE6) Mode 5: ports 1, 2, 5 are inputs after reset.
// (RULE7) Modes 5 and 6: direction bit 1 turns that pin to address output.
// (RULE8) Mode 5: address width chosen pin by pin via direction bits.
// (RULE9) Mode 6: ports 1, 2, 5 and port A 7..4 inputs after reset, except A20.
// (RULE10) Mode 6: port A 6..4 become A23..A21 when upper control bits 7..5 zero.
// (RULE11) Mode 6: direction bits 1 make ports 1, 2, 5 address lines.
// (RULE12) Mode 7: single chip, all ports general purpose.
// (RULE13) Board never selects mode 2 or 4.
// (RULE14) Modes 1, 3, 5, 6 run an 8-bit external bus.
// (RULE15) RAM and IO window sits elsewhere in 1 and 16 Mbyte modes.
// (RULE16) Address space decodes into eight areas.
// (RULE17) Port 3 is data bus in expanded modes, general port in mode 7.
// (RULE18) Modes 1, 5, 7: port A 7..4 never carry address lines.
// (RULE19) Mode pins stay steady at a supported value while running.
// (RULE20) Mode status low three bits give the pin levels latched at read.
module mode_address_pin_config
  import pinmux_pkg::*;
(
  input  wire logic        mclk_i,          // System clock
  input  wire logic        rstn_i,          // Async reset, low
  input  wire logic [2:0]  mode_pins_i,     // Mode pins high..low
  input  wire logic [23:0] cpu_addr_i,      // CPU address
  input  wire logic [31:0] s_axi_awaddr,    // AXI write address
  input  wire logic        s_axi_awvalid,   // AXI write address valid
  output logic             s_axi_awready,   // AXI write address ready
  input  wire logic [31:0] s_axi_wdata,     // AXI write data
  input  wire logic [3:0]  s_axi_wstrb,     // AXI byte strobes
  input  wire logic        s_axi_wvalid,    // AXI write data valid
  output logic             s_axi_wready,    // AXI write data ready
  output logic [1:0]       s_axi_bresp,     // AXI write response
  output logic             s_axi_bvalid,    // AXI write response valid
  input  wire logic        s_axi_bready,    // AXI write response ready
  input  wire logic [31:0] s_axi_araddr,    // AXI read address
  input  wire logic        s_axi_arvalid,   // AXI read address valid
  output logic             s_axi_arready,   // AXI read address ready
  output logic [31:0]      s_axi_rdata,     // AXI read data
  output logic [1:0]       s_axi_rresp,     // AXI read response
  output logic             s_axi_rvalid,    // AXI read valid
  input  wire logic        s_axi_rready,    // AXI read ready
  output logic [7:0]       port1_addr_en_o, // Port 1 pin is address A7..A0
  output logic [7:0]       port2_addr_en_o, // Port 2 pin is address A15..A8
  output logic [3:0]       port5_addr_en_o, // Port 5 pin is address A19..A16
  output logic [3:0]       porta_addr_en_o, // Port A 7..4 pin is address
  output logic             port3_data_bus_o,// Port 3 is data bus D7..D0
  output logic             bus_8bit_o,      // External bus is 8 bits
  output logic             expanded_o,      // Expanded mode active
  output logic             wide_space_o,    // 16 Mbyte space
  output logic [2:0]       area_o,          // Area of CPU address
  output logic             internal_hit_o   // CPU address hits RAM/IO window
);
  typedef struct packed {
    logic [7:0]  p1_dir;
    logic [7:0]  p2_dir;
    logic [3:0]  p5_dir;
    logic [7:0]  bus_rel;
    logic [7:0]  upper;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_ofs;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  p1_en;
    logic [7:0]  p2_en;
    logic [3:0]  p5_en;
    logic [3:0]  pa_en;
    logic        p3_bus;
    logic        b8;
    logic        exp;
    logic        wide;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
  } cfg_s;

  cfg_s        st_r;
  cfg_s        st_nxt;
  logic [2:0]  mode;
  logic [2:0]  mode_lat;
  logic        stat_rd;
  logic        rd_go;

  function automatic logic ofs_ok(input logic [31:0] a);
    ofs_ok = (a[31:8] == 24'h0) && (a[1:0] == 2'h0) && (a[7:0] <= OFS_MAP_STAT);
  endfunction : ofs_ok

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction : merge8

  assign rd_go   = s_axi_arvalid && !st_r.rvalid;
  assign stat_rd = rd_go && (s_axi_araddr[7:0] == OFS_MODE_STAT) && (s_axi_araddr[31:8] == 24'h0);

  mode_sampler u_samp (
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .mode_pins_i (mode_pins_i),
    .read_i      (stat_rd),
    .mode_o      (mode),
    .latched_o   (mode_lat)
  );

  area_decode u_area (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .wide_i     (st_r.wide),
    .addr_i     (cpu_addr_i),
    .area_o     (area_o),
    .internal_o (internal_hit_o)
  );

  always_comb
  begin
    logic [7:0]  wo;
    logic [7:0]  ra;
    wo     = 8'h00;
    ra     = 8'h00;
    st_nxt = st_r;
    // Write address and data accepted in either order
    if (s_axi_awvalid && !st_r.aw_got)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_ofs = s_axi_awaddr[7:0];
      if (s_axi_awaddr[31:8] != 24'h0)
      begin
        st_nxt.aw_ofs = 8'hff;
      end
    end
    if (s_axi_wvalid && !st_r.w_got)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
    begin
      wo            = st_r.aw_ofs;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      unique case (wo)
        OFS_PORT1_DIR: st_nxt.p1_dir = merge8(st_r.p1_dir, st_r.wdata, st_r.wstrb);
        OFS_PORT2_DIR: st_nxt.p2_dir = merge8(st_r.p2_dir, st_r.wdata, st_r.wstrb);
        OFS_PORT5_DIR: st_nxt.p5_dir = st_r.wstrb[0] ? st_r.wdata[3:0] : st_r.p5_dir;
        OFS_BUS_REL:   st_nxt.bus_rel = merge8(st_r.bus_rel, st_r.wdata, st_r.wstrb);
        OFS_UPPER_ADR: st_nxt.upper = merge8(st_r.upper, st_r.wdata, st_r.wstrb);
        OFS_MODE_STAT, OFS_PIN_STAT, OFS_MAP_STAT: st_nxt.bresp = RESP_OKAY;
        default:       st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (rd_go)
    begin
      ra            = s_axi_araddr[7:0];
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = ofs_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      st_nxt.rdata  = 32'h0;
      unique case (ra)
        OFS_PORT1_DIR: st_nxt.rdata[7:0] = st_r.p1_dir;
        OFS_PORT2_DIR: st_nxt.rdata[7:0] = st_r.p2_dir;
        OFS_PORT5_DIR: st_nxt.rdata[3:0] = st_r.p5_dir;
        OFS_BUS_REL:   st_nxt.rdata[7:0] = st_r.bus_rel;
        OFS_UPPER_ADR: st_nxt.rdata[7:0] = st_r.upper;
        OFS_MODE_STAT: st_nxt.rdata[7:0] = MODE_STAT_FIX | {5'h00, mode}; // RULE20
        OFS_PIN_STAT:  st_nxt.rdata[23:0] = {st_r.pa_en, st_r.p5_en, st_r.p2_en, st_r.p1_en};
        OFS_MAP_STAT:  st_nxt.rdata[3:0] = {st_r.p3_bus, st_r.b8, st_r.exp, st_r.wide};
        default:       st_nxt.rdata = 32'h0;
      endcase
    end
    else if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    // Pin function per mode; modes 2, 4 and 0 leave all pins as ports
    st_nxt.p1_en  = 8'h00;
    st_nxt.p2_en  = 8'h00;
    st_nxt.p5_en  = 4'h0;
    st_nxt.pa_en  = 4'h0; // RULE18
    st_nxt.exp    = 1'b0;
    st_nxt.wide   = 1'b0;
    unique case (mode)
      MODE_1:
      begin
        st_nxt.p1_en = 8'hff; // RULE1
        st_nxt.p2_en = 8'hff; // RULE1
        st_nxt.p5_en = 4'hf; // RULE1
        st_nxt.exp   = 1'b1;
      end
      MODE_3:
      begin
        st_nxt.p1_en = 8'hff; // RULE3
        st_nxt.p2_en = 8'hff; // RULE3
        st_nxt.p5_en = 4'hf; // RULE3
        st_nxt.pa_en = {st_r.bus_rel[UPPER_LSB +: 3] == UPPER_ENABLE ? 3'h7 : 3'h0, 1'b1}; // RULE4 RULE5
        st_nxt.exp   = 1'b1;
        st_nxt.wide  = 1'b1;
      end
      MODE_5:
      begin
        st_nxt.p1_en = st_r.p1_dir; // RULE6 RULE7 RULE8
        st_nxt.p2_en = st_r.p2_dir; // RULE7 RULE8
        st_nxt.p5_en = st_r.p5_dir; // RULE7 RULE8
        st_nxt.exp   = 1'b1;
      end
      MODE_6:
      begin
        st_nxt.p1_en = st_r.p1_dir; // RULE9 RULE11
        st_nxt.p2_en = st_r.p2_dir; // RULE11
        st_nxt.p5_en = st_r.p5_dir; // RULE11
        st_nxt.pa_en = {st_r.upper[UPPER_LSB +: 3] == UPPER_ENABLE ? 3'h7 : 3'h0, 1'b1}; // RULE10 RULE5
        st_nxt.exp   = 1'b1;
        st_nxt.wide  = 1'b1;
      end
      default:
      begin
        st_nxt.exp = 1'b0; // RULE12 RULE13
      end
    endcase
    st_nxt.p3_bus = st_nxt.exp; // RULE17
    st_nxt.b8     = st_nxt.exp; // RULE2 RULE14
    // Ready flags kept as flops so the bus outputs come straight from registers
    st_nxt.aw_rdy = !st_nxt.aw_got;
    st_nxt.w_rdy  = !st_nxt.w_got;
    st_nxt.ar_rdy = !st_nxt.rvalid;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_r         <= '0;
      st_r.p1_dir  <= DIR_RST;
      st_r.p2_dir  <= DIR_RST;
      st_r.p5_dir  <= P5_DIR_RST;
      st_r.bus_rel <= UPPER_RST;
      st_r.upper   <= UPPER_RST;
      st_r.aw_rdy  <= 1'b1;
      st_r.w_rdy   <= 1'b1;
      st_r.ar_rdy  <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready   = st_r.aw_rdy;
  assign s_axi_wready    = st_r.w_rdy;
  assign s_axi_bvalid    = st_r.bvalid;
  assign s_axi_bresp     = st_r.bresp;
  assign s_axi_arready   = st_r.ar_rdy;
  assign s_axi_rvalid    = st_r.rvalid;
  assign s_axi_rdata     = st_r.rdata;
  assign s_axi_rresp     = st_r.rresp;
  assign port1_addr_en_o = st_r.p1_en;
  assign port2_addr_en_o = st_r.p2_en;
  assign port5_addr_en_o = st_r.p5_en;
  assign porta_addr_en_o = st_r.pa_en;
  assign port3_data_bus_o = st_r.p3_bus;
  assign bus_8bit_o      = st_r.b8;
  assign expanded_o      = st_r.exp;
  assign wide_space_o    = st_r.wide;

  property p_mode1_addr;
    @(posedge mclk_i) disable iff (!rstn_i)
    $stable(mode) && mode == MODE_1 |=> port1_addr_en_o == 8'hff && port5_addr_en_o == 4'hf && porta_addr_en_o == 4'h0;
  endproperty
  a_mode1_addr: assert property (p_mode1_addr) else $error("mode 1 address pins wrong"); // RULE1

  property p_a20;
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode == MODE_3 || mode == MODE_6) |=> porta_addr_en_o[0];
  endproperty
  a_a20: assert property (p_a20) else $error("A20 not an address output"); // RULE5

  property p_mode3_upper;
    @(posedge mclk_i) disable iff (!rstn_i)
    mode == MODE_3 && st_r.bus_rel[7:5] != 3'h0 |=> porta_addr_en_o[3:1] == 3'h0;
  endproperty
  a_mode3_upper: assert property (p_mode3_upper) else $error("A23..A21 enabled too early"); // RULE4

  property p_mode6_upper;
    @(posedge mclk_i) disable iff (!rstn_i)
    $stable(mode) && mode == MODE_6 && st_r.upper[7:5] == 3'h0 |=> porta_addr_en_o[3:1] == 3'h7;
  endproperty
  a_mode6_upper: assert property (p_mode6_upper) else $error("A23..A21 not enabled"); // RULE10

  property p_dir_follow;
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode == MODE_5 || mode == MODE_6) |=> port1_addr_en_o == $past(st_r.p1_dir) && port5_addr_en_o == $past(st_r.p5_dir);
  endproperty
  a_dir_follow: assert property (p_dir_follow) else $error("direction bits not followed"); // RULE7

  property p_single_chip;
    @(posedge mclk_i) disable iff (!rstn_i)
    mode == MODE_7 |=> !port3_data_bus_o && port1_addr_en_o == 8'h00 && porta_addr_en_o == 4'h0;
  endproperty
  a_single_chip: assert property (p_single_chip) else $error("mode 7 pins not general purpose"); // RULE12

  property p_bus8;
    @(posedge mclk_i) disable iff (!rstn_i)
    mode == MODE_1 || mode == MODE_3 || mode == MODE_5 || mode == MODE_6 |=> bus_8bit_o && port3_data_bus_o && expanded_o;
  endproperty
  a_bus8: assert property (p_bus8) else $error("expanded bus not 8-bit data"); // RULE14

  sequence s_stat_read;
    stat_rd ##1 s_axi_rvalid;
  endsequence
  property p_stat_read;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_stat_read |-> s_axi_rdata[7:0] == (MODE_STAT_FIX | {5'h00, $past(mode)});
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("mode status mismatch"); // RULE20

  property p_stat_latch;
    @(posedge mclk_i) disable iff (!rstn_i)
    stat_rd |=> mode_lat == s_axi_rdata[2:0];
  endproperty
  a_stat_latch: assert property (p_stat_latch) else $error("latched mode level mismatch"); // RULE20

endmodule : mode_address_pin_config

// ---- tb/board_model.sv ----
`timescale 1ns/1ns
// Board strap: the mode pins follow the request, with 2 and 4 strapped as 7, only while the chip is in reset
module board_model
  import pinmux_pkg::*;
(
  input  wire logic       mclk_i,      // System clock
  input  wire logic       rstn_i,      // Chip reset, low
  input  wire logic [2:0] mode_req_i,  // Wanted strap setting
  output logic      [2:0] mode_pins_o  // Mode pins to the chip
);
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      mode_pins_o <= (mode_req_i == 3'h2 || mode_req_i == 3'h4) ? MODE_7 : mode_req_i;
  end
endmodule : board_model

// ---- tb/tb_mode_address_pin_config.sv ----
`timescale 1ns/1ns
module tb_mode_address_pin_config
  import pinmux_pkg::*;
;
  logic        mclk_i   = 1'h0;
  logic        rstn_i   = 1'h0;
  logic [2:0]  mode_req = 3'h1;
  logic [23:0] cpu_addr = 24'h0;
  logic [31:0] awaddr   = 32'h0;
  logic [31:0] wdata    = 32'h0;
  logic [31:0] araddr   = 32'h0;
  logic [3:0]  wstrb    = 4'h0;
  logic        awvalid  = 1'h0;
  logic        wvalid   = 1'h0;
  logic        bready   = 1'h0;
  logic        arvalid  = 1'h0;
  logic        rready   = 1'h0;
  logic [2:0]  mode_pins;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  p1_en, p2_en;
  logic [3:0]  p5_en, pa_en;
  logic        p3_bus, b8, exp_mode, wide, hit;
  logic [2:0]  area;
  int          err_count = 0;
  int          checked   = 0;

  always #50 mclk_i = ~mclk_i;

  board_model u_board_model (.mclk_i(mclk_i), .rstn_i(rstn_i), .mode_req_i(mode_req), .mode_pins_o(mode_pins));

  mode_address_pin_config u_mode_address_pin_config (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .mode_pins_i(mode_pins), .cpu_addr_i(cpu_addr),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port1_addr_en_o(p1_en), .port2_addr_en_o(p2_en), .port5_addr_en_o(p5_en),
    .porta_addr_en_o(pa_en), .port3_data_bus_o(p3_bus), .bus_8bit_o(b8),
    .expanded_o(exp_mode), .wide_space_o(wide), .area_o(area), .internal_hit_o(hit));

  task automatic test_done;
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One clock of a bounded wait; a hang ends the run
  task automatic tick(inout int n);
    @(posedge mclk_i);
    n++;
    if (n > 40)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, n, 32'h0);
      test_done();
    end
  endtask : tick

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk_i);
    awaddr  <= {24'h0, a};
    wdata   <= {24'h0, d};
    wstrb   <= 4'h1;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      tick(n);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
    end while (!(bvalid && bready));
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk_i);
    araddr  <= {24'h0, a};
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      tick(n);
      if (arvalid && arready)
        arvalid <= 1'h0;
    end while (!(rvalid && rready));
    chk({30'h0, rresp}, {30'h0, er});
    if (er == RESP_OKAY)
      chk({24'h0, rdata[7:0]}, {24'h0, ed});
    rready <= 1'h0;
  endtask : axi_rd

  // Strap a mode under reset, then read it back from the mode status word
  task automatic restart(input logic [2:0] m);
    @(posedge mclk_i);
    rstn_i   <= 1'h0;
    mode_req <= m;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'h1;
    repeat (4) @(posedge mclk_i);
    axi_rd(OFS_MODE_STAT, MODE_STAT_FIX | {5'h0, m}, RESP_OKAY);
  endtask : restart

  // Pin enables {p1,p2,p5,pa} and flags {p3 bus, 8 bit, expanded, wide} under mask k
  task automatic pins(input logic [23:0] e, input logic [3:0] f, input logic [3:0] k);
    @(posedge mclk_i);
    chk({8'h0, p1_en, p2_en, p5_en, pa_en}, {8'h0, e});
    chk({28'h0, {p3_bus, b8, exp_mode, wide} & k}, {28'h0, f & k});
  endtask : pins

  task automatic area_chk(input logic [23:0] a, input logic [2:0] ea, input logic eh);
    cpu_addr <= a;
    repeat (2) @(posedge mclk_i);
    chk({28'h0, hit, area}, {28'h0, eh, ea});
  endtask : area_chk

  initial
  begin
    restart(MODE_1);
    pins(24'hfffff0, 4'he, 4'hf);
    area_chk(24'h0f0000, 3'h7, 1'h1);
    area_chk(24'hf00000, 3'h0, 1'h0);
    restart(MODE_3);
    pins(24'hfffff1, 4'hf, 4'hf);
    axi_wr(OFS_BUS_REL, 8'h1f, RESP_OKAY);
    pins(24'hffffff, 4'hf, 4'hf);
    area_chk(24'ha00000, 3'h5, 1'h0);
    area_chk(24'hf12345, 3'h7, 1'h1);
    restart(MODE_5);
    pins(24'h000000, 4'he, 4'hf);
    axi_wr(OFS_PORT1_DIR, 8'h5a, RESP_OKAY);
    axi_wr(OFS_PORT5_DIR, 8'h03, RESP_OKAY);
    pins(24'h5a0030, 4'he, 4'hf);
    axi_rd(OFS_PORT1_DIR, 8'h5a, RESP_OKAY);
    restart(MODE_6);
    pins(24'h000001, 4'hf, 4'hf);
    axi_wr(OFS_PORT2_DIR, 8'hff, RESP_OKAY);
    pins(24'h00ff01, 4'hf, 4'hf);
    axi_wr(OFS_UPPER_ADR, 8'h1f, RESP_OKAY);
    pins(24'h00ff0f, 4'hf, 4'hf);
    restart(MODE_7);
    axi_wr(OFS_PORT1_DIR, 8'hff, RESP_OKAY);
    pins(24'h000000, 4'h0, 4'hb);
    axi_wr(8'h40, 8'h00, RESP_SLVERR);
    axi_rd(8'h02, 8'h00, RESP_SLVERR);
    axi_wr(OFS_MODE_STAT, 8'h00, RESP_OKAY);
    axi_rd(OFS_MODE_STAT, MODE_STAT_FIX | 8'h07, RESP_OKAY);
    test_done();
  end
endmodule : tb_mode_address_pin_config
